//--- hdl/acrmc_control.sv
`timescale 1ns/1ps
`include "acrmc_regs.svh"
module acrmc_control
  import acrmc_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic link_clk,
  input wire logic link_nrst,
  input wire logic setup_write,
  input wire acrmc_setup_t setup_data,
  input wire logic conv_write,
  input wire acrmc_request_t conv_req,
  input wire logic convert_start_pin,
  input wire logic scan_done,
  output logic [1:0] clock_mode,
  output logic [1:0] reference_mode,
  output logic internal_clock_sel,
  output logic acq_by_pin,
  output logic start_pin_is_input,
  output logic analog_input_seven,
  output logic track,
  output logic internal_ref_on,
  output logic dac_uses_ext_ref,
  output logic conv_go,
  output logic conv_skip,
  output logic temp_result_ready
);

  // ****************************************
  // Parameter check
  // ****************************************
  // Counter must hold the longest wake-up load with headroom
  if (CNT_W < 9) begin : g_cnt_w_check
    $error("CNT_W too small for wake-up counts");
  end

  // ****************************************
  // Internal signals
  // ****************************************
  // Sequencer state and wake-up counter
  acrmc_state_t state;
  acrmc_state_t next_state;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic [7:0] div;

  // Pin synchroniser stages
  logic pin_s1;
  logic pin_s2;
  logic pin_d;

  // Latched request fields
  logic req_temp;
  logic [2:0] req_chan;
  logic [3:0] req_pairs;

  // Link tick crossing
  logic link_tgl;
  logic ltg_s1;
  logic ltg_s2;
  logic ltg_d;

  // Reference warm flag
  logic ref_warm;

  // ****************************************
  // Helper functions
  // ****************************************
  // Last tick of a wake-up count, or count already spent
  function automatic logic count_done(
    input logic [CNT_W-1:0] count,
    input logic tick
  );
    count_done = (count == '0) || (tick && count == CNT_W'(1));
  endfunction

  // Count one conversion clock tick down
  function automatic logic [CNT_W-1:0] count_down(
    input logic [CNT_W-1:0] count,
    input logic tick
  );
    count_down = tick ? count - CNT_W'(1) : count;
  endfunction

  // A channel, or the pair 6/7, lands on the given pin
  function automatic logic pin_claimed(
    input logic [2:0] chan,
    input logic [3:0] pairs,
    input logic [2:0] pin
  );
    pin_claimed = (chan == pin) | (pairs[3] & chan[2:1] == 2'h3);
  endfunction

  // ****************************************
  // Setup register
  // ****************************************
  // Setup register, reset mode 10 for both fields
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      clock_mode <= `ACRMC_CLK_MODE_RST; // [RULE_13]
      reference_mode <= `ACRMC_REF_MODE_RST; // [RULE_09]
    end else if (setup_write) begin
      clock_mode <= setup_data.clock_mode;
      reference_mode <= setup_data.reference_mode;
    end
  end

  // Clock mode decode
  assign internal_clock_sel = (clock_mode != 2'h3); // [RULE_01]
  assign acq_by_pin = (clock_mode == 2'h1); // [RULE_01]
  assign start_pin_is_input = !clock_mode[1]; // [RULE_04]

  // Reference mode decode
  wire ext_ref = reference_mode[0]; // [RULE_08]
  wire adc_external_reference_pin_is_ref = ext_ref;

  // DAC reference pin in use unless all internal
  assign dac_uses_ext_ref = reference_mode[1] | reference_mode[0];

  // ****************************************
  // Pin synchroniser
  // ****************************************
  // Two stages before any logic looks at the pin
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      pin_s1 <= 1'h1;
      pin_s2 <= 1'h1;
      pin_d <= 1'h1;
    end else begin
      pin_s1 <= convert_start_pin;
      pin_s2 <= pin_s1;
      pin_d <= pin_s2;
    end
  end
  // Rising edge of the synchronised pin
  wire pin_rise = !pin_d & pin_s2;
  // Pin level forwarded when it serves as channel seven
  assign analog_input_seven = clock_mode[1] ? pin_s2 : 1'h0; // [RULE_04]

  // ****************************************
  // Link clock edge detection
  // ****************************************
  // Toggle on every rising edge of the external conversion clock
  always_ff @(posedge link_clk) begin
    if (!link_nrst) begin
      link_tgl <= 1'h0;
    end else begin
      link_tgl <= !link_tgl;
    end
  end

  // Toggle crosses through two flops into core domain
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      ltg_s1 <= 1'h0;
      ltg_s2 <= 1'h0;
      ltg_d <= 1'h0;
    end else begin
      ltg_s1 <= link_tgl;
      ltg_s2 <= ltg_s1;
      ltg_d <= ltg_s2;
    end
  end
  // One tick per link clock rising edge, seen after the crossing
  wire ext_tick = ltg_s2 ^ ltg_d; // [RULE_03]

  // ****************************************
  // Conversion clock
  // ****************************************
  // Internal conversion clock from a divider
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      div <= 8'h00;
    end else if (div == `ACRMC_INT_DIV - 8'h01) begin
      div <= 8'h00;
    end else begin
      div <= div + 8'h01;
    end
  end
  wire int_tick = (div == `ACRMC_INT_DIV - 8'h01);
  // Selected conversion clock tick
  wire conv_tick = internal_clock_sel ? int_tick : ext_tick; // [RULE_16]

  // ****************************************
  // Scan start and channel screening
  // ****************************************
  // Start sources; the pin start is taken at the end of the low pulse
  wire start_write = conv_write & clock_mode[1]; // [RULE_14]
  wire start_pulse = pin_rise & !clock_mode[1]; // [RULE_14]
  // Starts while busy are ignored
  wire scan_start = (state == ACRMC_IDLE) & (start_write | start_pulse);
  // Channel fields from the write or the latch
  wire [2:0] chan_now = conv_write ? conv_req.channel : req_chan;
  wire [3:0] pair_now = conv_write ? conv_req.pair_mask : req_pairs;
  // Channels whose pin has another job
  wire pin7_taken = start_pin_is_input &
    pin_claimed(chan_now, pair_now, 3'h7);
  wire pin6_taken = adc_external_reference_pin_is_ref &
    pin_claimed(chan_now, pair_now, 3'h6);
  wire chan_blocked = pin7_taken | pin6_taken; // [RULE_15]

  // ****************************************
  // Acquisition tracking
  // ****************************************
  // Tracking: pin low in mode 01 holds acquisition
  assign track = acq_by_pin & !pin_s2 & (state == ACRMC_IDLE); // [RULE_02]

  // ****************************************
  // Request capture
  // ****************************************
  // Request capture
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      req_temp <= 1'h0;
      req_chan <= 3'h0;
      req_pairs <= 4'h0;
    end else if (conv_write) begin
      req_temp <= conv_req.temperature;
      req_chan <= conv_req.channel;
      req_pairs <= conv_req.pair_mask;
    end
  end

  // ****************************************
  // Wake-up sequencer
  // ****************************************
  // Temperature flag from the write or the latch
  wire temp_now = conv_write ? conv_req.temperature : req_temp;
  // Loads sized to the counter on purpose
  wire [CNT_W-1:0] ref_wake_load = CNT_W'(`ACRMC_REF_WAKE_CYC);
  wire [CNT_W-1:0] temp_wake_load = CNT_W'(`ACRMC_TEMP_WAKE_CYC);
  wire [CNT_W-1:0] temp_out_load = CNT_W'(`ACRMC_TEMP_OUT_CYC);
  // Reference already on from an earlier temperature request
  wire warm = ref_warm;

  // Next-state logic for delays
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    case (state)
      ACRMC_IDLE: begin
        if (scan_start) begin
          if (temp_now) begin
            next_state = ACRMC_WAKE;
            next_cnt = temp_wake_load; // [RULE_07] [RULE_11]
          end else if (!ext_ref && !warm) begin
            next_state = ACRMC_WAKE;
            next_cnt = ref_wake_load; // [RULE_06] [RULE_10]
          end else begin
            next_state = ACRMC_CONV;
          end
        end
      end
      ACRMC_WAKE: begin
        next_cnt = count_down(cnt, conv_tick);
        if (count_done(cnt, conv_tick)) begin // [RULE_16]
          if (req_temp && !internal_clock_sel) begin
            next_state = ACRMC_TEMP_WAIT;
            next_cnt = temp_out_load; // [RULE_12]
          end else begin
            next_state = ACRMC_CONV;
          end
        end
      end
      ACRMC_TEMP_WAIT: begin
        next_cnt = count_down(cnt, conv_tick);
        if (count_done(cnt, conv_tick)) begin // [RULE_12]
          next_state = ACRMC_CONV;
        end
      end
      ACRMC_CONV: begin
        if (scan_done) begin
          next_state = ACRMC_DONE;
        end
      end
      ACRMC_DONE: begin
        next_state = ACRMC_IDLE;
      end
      default: begin
        next_state = ACRMC_IDLE;
      end
    endcase
  end

  // ****************************************
  // Sequencer registers
  // ****************************************
  // State and counter registers
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      state <= ACRMC_IDLE;
      cnt <= '0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
    end
  end

  // ****************************************
  // Reference power
  // ****************************************
  // Reference power: on for wake and scan, off after analog-only scan
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      ref_warm <= 1'h0;
    end else if (next_state == ACRMC_WAKE) begin
      ref_warm <= 1'h1;
    end else if (state == ACRMC_DONE && !req_temp) begin
      ref_warm <= 1'h0; // [RULE_05]
    end else if (state == ACRMC_DONE && ext_ref) begin
      ref_warm <= 1'h0; // [RULE_08]
    end else if (state == ACRMC_IDLE && ext_ref) begin
      ref_warm <= 1'h0; // [RULE_08]
    end
  end
  // Reference on while warm or while converting on it
  assign internal_ref_on = ref_warm | (state == ACRMC_CONV & !ext_ref);

  // ****************************************
  // Sequencer outputs
  // ****************************************
  // Outputs of the sequencer
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      conv_go <= 1'h0;
      conv_skip <= 1'h0;
      temp_result_ready <= 1'h0;
    end else begin
      conv_go <= (next_state == ACRMC_CONV) & (state != ACRMC_CONV) &
        !chan_blocked; // [RULE_16]
      conv_skip <= (next_state == ACRMC_CONV) & (state != ACRMC_CONV) &
        chan_blocked; // [RULE_15]
      temp_result_ready <= (state == ACRMC_TEMP_WAIT) &
        (next_state == ACRMC_CONV); // [RULE_12]
    end
  end

endmodule // acrmc_control

//--- pkg/acrmc_pkg.sv
package acrmc_pkg;
  typedef enum logic [2:0] {
    ACRMC_IDLE = 3'b000,
    ACRMC_WAKE = 3'b001,
    ACRMC_TEMP_WAIT = 3'b010,
    ACRMC_CONV = 3'b011,
    ACRMC_DONE = 3'b100
  } acrmc_state_t;
  typedef struct packed {
    logic [1:0] clock_mode;
    logic [1:0] reference_mode;
  } acrmc_setup_t;
  typedef struct packed {
    logic [2:0] channel;
    logic temperature;
    logic [3:0] pair_mask;
  } acrmc_request_t;
endpackage

//--- pkg/acrmc_regs.svh
// Operation
// [RULE_01] Clock mode field picks clock and timing
// [RULE_02] Mode 01: pin low time sets tracking
// [RULE_03] Mode 11: host serial clock converts, 3.6MHz
// [RULE_04] Modes 1x: start pin is channel seven
// [RULE_05] Internal reference off after analog-only scan
// [RULE_06] Cold reference: wait 218 internal clocks
// [RULE_07] Temperature: reference on, wait 244 clocks
// [RULE_08] External reference modes leave internal unused
// [RULE_09] Reset reference mode is 10
// [RULE_10] Mode 11 cold reference: 218 external clocks
// [RULE_11] Mode 11 temperature: 244 external clocks
// [RULE_12] Mode 11 temperature: 188 more, then output
// [RULE_13] Clock mode upper bit resets to one
// [RULE_14] Modes 1x start by write, 0x by pulse
// [RULE_15] Skip channels used as start or reference
// [RULE_16] Delays count selected clock, then convert
`ifndef ACRMC_REGS_SVH
`define ACRMC_REGS_SVH
`define ACRMC_CLK_MODE_RST 2'h2
`define ACRMC_REF_MODE_RST 2'h2
`define ACRMC_REF_WAKE_CYC 16'h00DA
`define ACRMC_TEMP_WAKE_CYC 16'h00F4
`define ACRMC_TEMP_OUT_CYC 16'h00BC
`define ACRMC_INT_DIV 8'h04
`define ACRMC_EXT_CLK_MAX_KHZ 3600
`endif

//--- verif/acrmc_control_sva.sv
`timescale 1ns/1ps
module acrmc_control_sva
  import acrmc_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic conv_write,
  input wire acrmc_request_t conv_req,
  input wire logic [1:0] clock_mode,
  input wire logic [1:0] reference_mode,
  input wire logic internal_clock_sel,
  input wire logic acq_by_pin,
  input wire logic start_pin_is_input,
  input wire logic analog_input_seven,
  input wire logic track,
  input wire logic internal_ref_on,
  input wire logic dac_uses_ext_ref,
  input wire logic conv_go,
  input wire logic conv_skip
);
  // ********
  // Checks
  // ********
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // Cold reference analog start in mode 10
  sequence cold_start;
    conv_write && clock_mode == 2'h2 && reference_mode == 2'h2 &&
      !internal_ref_on && !conv_req.temperature;
  endsequence
  a_clock_decode: assert property (
    internal_clock_sel == (clock_mode != 2'h3)) else $error("clock sel");
  a_acq_timing: assert property (
    acq_by_pin == (clock_mode == 2'h1)) else $error("acq sel");
  a_track_mode: assert property (
    track |-> clock_mode == 2'h1) else $error("track mode");
  a_pin_role: assert property (
    start_pin_is_input == !clock_mode[1]) else $error("pin role");
  a_ain_seven: assert property (
    !clock_mode[1] |-> !analog_input_seven) else $error("ain seven");
  a_reset_modes: assert property (disable iff (1'b0)
    !nrst |=> clock_mode == 2'h2 && reference_mode == 2'h2)
    else $error("reset modes");
  a_dac_ref: assert property (
    dac_uses_ext_ref == (reference_mode != 2'h0)) else $error("dac ref");
  a_one_answer: assert property (
    !(conv_go && conv_skip)) else $error("go and skip");
  a_cold_wait: assert property (
    cold_start |=> !(conv_go || conv_skip) [*8]) else $error("no wake wait");
endmodule // acrmc_control_sva
bind acrmc_control acrmc_control_sva acrmc_control_sva_inst (
  .core_clk, .nrst, .conv_write, .conv_req, .clock_mode, .reference_mode,
  .internal_clock_sel, .acq_by_pin, .start_pin_is_input,
  .analog_input_seven, .track, .internal_ref_on, .dac_uses_ext_ref,
  .conv_go, .conv_skip);

//--- verif/acrmc_host_model.sv
`timescale 1ns/1ps
module acrmc_host_model (
  input wire logic run,
  output logic link_clk,
  output int ticks
);
  // Serial clock 48 ns, still when not running
  initial begin
    link_clk = 1'b0;
    ticks = 0;
    #7;
    forever begin
      #24;
      if (run) begin
        link_clk = ~link_clk;
        if (link_clk) ticks++;
      end else link_clk = 1'b0;
    end
  end
endmodule // acrmc_host_model

//--- verif/testbench.sv
`timescale 1ns/1ps
module testbench;
  import acrmc_pkg::*;
  logic core_clk, nrst, link_clk, link_nrst, run, setup_write, conv_write;
  logic convert_start_pin, scan_done, internal_clock_sel, acq_by_pin;
  logic start_pin_is_input, analog_input_seven, track, internal_ref_on;
  logic dac_uses_ext_ref, conv_go, conv_skip, temp_result_ready;
  logic [1:0] clock_mode, reference_mode;
  acrmc_setup_t setup_data;
  acrmc_request_t conv_req;
  int ticks, error_cnt, n_checks, cyc, t0;
  acrmc_control acrmc_control_inst (.core_clk, .nrst, .link_clk, .link_nrst,
    .setup_write, .setup_data, .conv_write, .conv_req, .convert_start_pin,
    .scan_done, .clock_mode, .reference_mode, .internal_clock_sel,
    .acq_by_pin, .start_pin_is_input, .analog_input_seven, .track,
    .internal_ref_on, .dac_uses_ext_ref, .conv_go, .conv_skip,
    .temp_result_ready);
  acrmc_host_model acrmc_host_model_inst (.run, .link_clk, .ticks);
  // ********
  // Tasks
  // ********
  task automatic check(input string nm, input logic [15:0] s,
                       input logic [15:0] e);
    n_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic setup(input logic [1:0] cm, input logic [1:0] rm);
    @(posedge core_clk);
    setup_write <= 1'b1;
    setup_data <= '{cm, rm};
    @(posedge core_clk);
    setup_write <= 1'b0;
    step(3);
  endtask
  task automatic convert(input logic [2:0] ch, input logic tmp);
    @(posedge core_clk);
    conv_write <= 1'b1;
    conv_req <= '{ch, tmp, 4'h0};
    @(posedge core_clk);
    conv_write <= 1'b0;
  endtask
  // Count cycles until answer pulse, bounded
  task automatic wait_pulse(input int lim, input logic tmp);
    cyc = 0;
    #1;
    while (cyc < lim &&
           (tmp ? temp_result_ready : conv_go | conv_skip) !== 1'b1) begin
      step(1);
      cyc++;
    end
  endtask
  task automatic end_scan;
    @(posedge core_clk);
    scan_done <= 1'b1;
    @(posedge core_clk);
    scan_done <= 1'b0;
    step(4);
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Clock and watchdog
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    #500us;
    error_cnt++;
    complete_run();
  end
  // Test sequence
  initial begin
    {nrst, link_nrst, setup_write, conv_write, scan_done} = 5'h00;
    {run, convert_start_pin, setup_data, conv_req} = '0;
    convert_start_pin = 1'b1;
    run = 1'b1;
    step(20);
    {nrst, link_nrst, run} <= 3'h6;
    step(1);
    check("clock_mode", clock_mode, 2'h2);
    check("reference_mode", reference_mode, 2'h2);
    check("dac_ref", dac_uses_ext_ref, 1'b1);
    for (int m = 0; m < 4; m++) begin
      setup(m[1:0], 2'h2);
      check("int_clk", internal_clock_sel, m != 3);
      check("acq_pin", acq_by_pin, m == 1);
      check("pin_in", start_pin_is_input, m < 2);
    end
    setup(2'h2, 2'h2);
    convert(3'h0, 1'b0);
    wait_pulse(2000, 1'b0);
    check("cold", cyc >= 868 && cyc <= 873, 1'b1);
    end_scan();
    check("ref_off", internal_ref_on, 1'b0);
    convert(3'h0, 1'b1);
    step(3);
    check("ref_on", internal_ref_on, 1'b1);
    wait_pulse(2000, 1'b0);
    check("temp", cyc >= 968 && cyc <= 973, 1'b1);
    end_scan();
    setup(2'h2, 2'h1);
    convert(3'h6, 1'b0);
    wait_pulse(20, 1'b0);
    check("skip", conv_skip, 1'b1);
    check("ext_ref", internal_ref_on, 1'b0);
    end_scan();
    setup(2'h1, 2'h1);
    convert(3'h0, 1'b0);
    wait_pulse(10, 1'b0);
    check("no_start", cyc, 16'h000A);
    convert_start_pin <= 1'b0;
    step(5);
    check("track", track, 1'b1);
    convert_start_pin <= 1'b1;
    wait_pulse(20, 1'b0);
    check("pin_go", conv_go, 1'b1);
    end_scan();
    run <= 1'b1;
    step(20);
    setup(2'h3, 2'h2);
    check("analog_input_seven", analog_input_seven, 1'b1);
    t0 = ticks;
    convert(3'h0, 1'b0);
    wait_pulse(3000, 1'b0);
    t0 = ticks - t0;
    check("ext_cold", t0 >= 217 && t0 <= 219, 1'b1);
    end_scan();
    t0 = ticks;
    convert(3'h0, 1'b1);
    wait_pulse(5000, 1'b1);
    t0 = ticks - t0;
    check("ext_temp", t0 >= 431 && t0 <= 433, 1'b1);
    complete_run();
  end
endmodule // testbench
